// ==== fsta_map.vh ====
// constants for the far skip / table / add execution unit
// assumes one core clock; opcodes come from the core's instruction decoder
// Operation
// RULE_01 - far address holds sector bits; any sector reached directly, no indirection
// RULE_02 - far zero test skips on zero, nonzero test on nonzero; flags kept
// RULE_03 - zero test with move copies byte to work register, skips on zero
// RULE_04 - far bit tests skip on selected bit clear, or on set
// RULE_05 - far increment/decrement test writes memory back, skips on new zero
// RULE_06 - work variants put adjusted value in work register, memory kept
// RULE_07 - far skip op takes three cycles when skipping, two otherwise
// RULE_08 - far op changing program counter low byte takes three cycles; add and adc into memory still take one cycle
// RULE_09 - page table fetch: high part to table high, low to memory, three cycles
// RULE_10 - final page table fetch uses last program page, three cycles
// RULE_11 - preincrement variants bump table pointer first; three cycles, no flags
// RULE_12 - far zero fill and ones fill write byte, two cycles, no flags
// RULE_13 - far nibble exchange swaps halves into memory, two cycles, no flags
// RULE_14 - nibble exchange to work writes work register, memory kept, two cycles
// RULE_15 - add with carry to work: work plus byte plus carry, five flags
// RULE_16 - add with carry to memory: same sum into memory, five flags
// RULE_17 - add from memory: work plus byte into work, five flags
// RULE_18 - immediate add: work plus literal into work, five flags
// RULE_19 - sum into memory: work plus byte into memory, five flags
// RULE_20 - memory and: bitwise and into work, only zero flag
// RULE_21 - immediate and: bitwise and with literal into work, only zero flag
// RULE_22 - add flags: zero, carry bit7, half carry bit3, signed overflow
// RULE_23 - skip discards fetched next instruction as one dummy cycle
`ifndef FSTA_MAP_VH
`define FSTA_MAP_VH
// ==============================
// widths and places
`define FSTA_DM_AW 6
`define FSTA_DM_DEPTH 64
`define FSTA_SECTOR_LSB 4
`define FSTA_PCL_ADDR 6'h02
`define FSTA_LAST_PAGE 8'hFF
// ==============================
// cycle counts
`define FSTA_CYC_BASE 2'h1
`define FSTA_CYC_FAR 2'h2
`define FSTA_CYC_LONG 2'h3
// ==============================
// reset values
`define FSTA_RST_BYTE 8'h00
`define FSTA_RST_WORD 16'h0000
// ==============================
// opcodes
`define FSTA_OP_SKIP_ZERO 5'h00
`define FSTA_OP_SKIP_ZERO_MOVE 5'h01
`define FSTA_OP_SKIP_NONZERO 5'h02
`define FSTA_OP_SKIP_BIT_CLEAR 5'h03
`define FSTA_OP_SKIP_BIT_SET 5'h04
`define FSTA_OP_INCR_SKIP 5'h05
`define FSTA_OP_DECR_SKIP 5'h06
`define FSTA_OP_INCR_SKIP_WORK 5'h07
`define FSTA_OP_DECR_SKIP_WORK 5'h08
`define FSTA_OP_TABLE_PAGE 5'h09
`define FSTA_OP_TABLE_FINAL 5'h0A
`define FSTA_OP_PREINC_PAGE 5'h0B
`define FSTA_OP_PREINC_FINAL 5'h0C
`define FSTA_OP_ZERO_FILL 5'h0D
`define FSTA_OP_ONES_FILL 5'h0E
`define FSTA_OP_NIBBLE_MEM 5'h0F
`define FSTA_OP_NIBBLE_WORK 5'h10
`define FSTA_OP_ADC_WORK 5'h11
`define FSTA_OP_ADC_MEM 5'h12
`define FSTA_OP_ADD_WORK 5'h13
`define FSTA_OP_ADD_IMM 5'h14
`define FSTA_OP_ADD_MEM 5'h15
`define FSTA_OP_AND_WORK 5'h16
`define FSTA_OP_AND_IMM 5'h17
`endif

// ==== fsta_exec_unit.v ====
// execution unit for far skip, table fetch, fill, nibble and add/and ops
// assumes opcode, operands and program word come from logic on clk
`timescale 1ns/100ps
`include "fsta_map.vh"
module fsta_exec_unit (
   // clock and reset
   input wire clk,
   input wire nrst,
   // instruction issue
   input wire start,
   input wire [4:0] opcode,
   input wire [`FSTA_DM_AW-1:0] farAddr,
   input wire [2:0] bitSel,
   input wire [7:0] literal,
   input wire [7:0] tablePage,
   // program memory fetch
   input wire [15:0] progWord,
   output reg progReq_r,
   output reg [15:0] progAddr_r,
   // data memory read-out
   input wire [`FSTA_DM_AW-1:0] peekAddr,
   output reg [7:0] peekData_r,
   // status
   output reg busy_r,
   output reg done_r,
   output reg skip_r,
   output reg dummy_r,
   output reg pclChanged_r,
   // core registers
   output reg [7:0] work_register_r,
   output reg [7:0] table_high_byte_r,
   output reg [7:0] table_pointer_r,
   // flags
   output reg zeroFlag_r,
   output reg carryFlag_r,
   output reg half_carry_flag_r,
   output reg signed_wrap_flag_r,
   output reg signed_carry_flag_r
);
   // ==============================
   // reset synchroniser
   reg rstMeta_r;
   reg rstSync_r;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // ==============================
   // helpers
   // {ov, hc, c, sum}
   function [10:0] addFlags;
      input [7:0] a;
      input [7:0] b;
      input cin;
      reg [4:0] lo;
      reg [8:0] full;
      begin
         lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         addFlags = {(a[7] == b[7]) && (full[7] != a[7]), lo[4], full[8], full[7:0]};
      end
   endfunction

   function [7:0] swapHalves;
      input [7:0] v;
      begin
         swapHalves = {v[3:0], v[7:4]};
      end
   endfunction

   // ==============================
   // state
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN = 2'h1;
   reg [1:0] state_r;
   reg [1:0] left_r;
   reg [1:0] left_nxt;
   reg tableWait_r;
   reg [`FSTA_DM_AW-1:0] tableDest_r;
   reg skipPend_r;
   reg [7:0] mem_r [0:`FSTA_DM_DEPTH-1];
   integer i;

   // ==============================
   // decode and compute for the accepted instruction
   // far address carries the sector bits, so every sector is one flat index
   wire [7:0] operand = mem_r[farAddr]; // [RULE_01]
   wire [7:0] incVal = operand + 8'h01;
   wire [7:0] decVal = operand - 8'h01;
   reg [7:0] memVal;
   reg memWr;
   reg [7:0] workVal;
   reg workWr;
   reg arithFlags;
   reg zeroOnly;
   reg [10:0] sum;
   reg doSkip;
   reg isTable;
   reg [1:0] len;

   always @* begin
      memVal = operand;
      memWr = 1'b0;
      workVal = work_register_r;
      workWr = 1'b0;
      arithFlags = 1'b0;
      zeroOnly = 1'b0;
      sum = addFlags(work_register_r, operand, 1'b0);
      doSkip = 1'b0;
      isTable = 1'b0;
      len = `FSTA_CYC_FAR;
      case (opcode)
         `FSTA_OP_SKIP_ZERO: begin
            doSkip = (operand == 8'h00); // [RULE_02]
         end
         `FSTA_OP_SKIP_NONZERO: begin
            doSkip = (operand != 8'h00); // [RULE_02]
         end
         `FSTA_OP_SKIP_ZERO_MOVE: begin
            workVal = operand; // [RULE_03]
            workWr = 1'b1;
            doSkip = (operand == 8'h00); // [RULE_03]
         end
         `FSTA_OP_SKIP_BIT_CLEAR: begin
            doSkip = !operand[bitSel]; // [RULE_04]
         end
         `FSTA_OP_SKIP_BIT_SET: begin
            doSkip = operand[bitSel]; // [RULE_04]
         end
         `FSTA_OP_INCR_SKIP: begin
            memVal = incVal; // [RULE_05]
            memWr = 1'b1;
            doSkip = (incVal == 8'h00); // [RULE_05]
         end
         `FSTA_OP_DECR_SKIP: begin
            memVal = decVal; // [RULE_05]
            memWr = 1'b1;
            doSkip = (decVal == 8'h00); // [RULE_05]
         end
         `FSTA_OP_INCR_SKIP_WORK: begin
            workVal = incVal; // [RULE_06]
            workWr = 1'b1;
            doSkip = (incVal == 8'h00); // [RULE_06]
         end
         `FSTA_OP_DECR_SKIP_WORK: begin
            workVal = decVal; // [RULE_06]
            workWr = 1'b1;
            doSkip = (decVal == 8'h00); // [RULE_06]
         end
         `FSTA_OP_TABLE_PAGE, `FSTA_OP_TABLE_FINAL,
         `FSTA_OP_PREINC_PAGE, `FSTA_OP_PREINC_FINAL: begin
            isTable = 1'b1; // [RULE_09] [RULE_10] [RULE_11]
         end
         `FSTA_OP_ZERO_FILL: begin
            memVal = 8'h00; // [RULE_12]
            memWr = 1'b1;
         end
         `FSTA_OP_ONES_FILL: begin
            memVal = 8'hFF; // [RULE_12]
            memWr = 1'b1;
         end
         `FSTA_OP_NIBBLE_MEM: begin
            memVal = swapHalves(operand); // [RULE_13]
            memWr = 1'b1;
         end
         `FSTA_OP_NIBBLE_WORK: begin
            workVal = swapHalves(operand); // [RULE_14]
            workWr = 1'b1;
         end
         `FSTA_OP_ADC_WORK: begin
            sum = addFlags(work_register_r, operand, carryFlag_r); // [RULE_15]
            workVal = sum[7:0];
            workWr = 1'b1;
            arithFlags = 1'b1;
            len = `FSTA_CYC_BASE;
         end
         `FSTA_OP_ADC_MEM: begin
            sum = addFlags(work_register_r, operand, carryFlag_r); // [RULE_16]
            memVal = sum[7:0];
            memWr = 1'b1;
            arithFlags = 1'b1;
            len = `FSTA_CYC_BASE;
         end
         `FSTA_OP_ADD_WORK: begin
            workVal = sum[7:0]; // [RULE_17]
            workWr = 1'b1;
            arithFlags = 1'b1;
            len = `FSTA_CYC_BASE;
         end
         `FSTA_OP_ADD_IMM: begin
            sum = addFlags(work_register_r, literal, 1'b0); // [RULE_18]
            workVal = sum[7:0];
            workWr = 1'b1;
            arithFlags = 1'b1;
            len = `FSTA_CYC_BASE;
         end
         `FSTA_OP_ADD_MEM: begin
            memVal = sum[7:0]; // [RULE_19]
            memWr = 1'b1;
            arithFlags = 1'b1;
            len = `FSTA_CYC_BASE;
         end
         `FSTA_OP_AND_WORK: begin
            workVal = work_register_r & operand; // [RULE_20]
            workWr = 1'b1;
            zeroOnly = 1'b1;
            len = `FSTA_CYC_BASE;
         end
         `FSTA_OP_AND_IMM: begin
            workVal = work_register_r & literal; // [RULE_21]
            workWr = 1'b1;
            zeroOnly = 1'b1;
            len = `FSTA_CYC_BASE;
         end
         default: begin
            len = `FSTA_CYC_BASE;
         end
      endcase
      // one extra cycle for the discarded next instruction
      if (doSkip) begin
         len = `FSTA_CYC_LONG; // [RULE_07] [RULE_23]
      end
      // a two-cycle far write to the low program counter refetches, costing a cycle
      if (memWr && (farAddr == `FSTA_PCL_ADDR) && (len == `FSTA_CYC_FAR)) begin
         len = `FSTA_CYC_LONG; // [RULE_08]
      end
      if (isTable) begin
         len = `FSTA_CYC_LONG; // [RULE_09] [RULE_10] [RULE_11]
      end
   end

   wire accept = start && (state_r == ST_IDLE) && rstSync_r;
   wire preInc = (opcode == `FSTA_OP_PREINC_PAGE) || (opcode == `FSTA_OP_PREINC_FINAL);
   wire finalPage = (opcode == `FSTA_OP_TABLE_FINAL) || (opcode == `FSTA_OP_PREINC_FINAL);
   wire [7:0] ptrUsed = preInc ? table_pointer_r + 8'h01 : table_pointer_r; // [RULE_11]
   wire [7:0] pageUsed = finalPage ? `FSTA_LAST_PAGE : tablePage; // [RULE_10]

   always @* begin
      left_nxt = left_r;
      if (left_r != 2'h0) begin
         left_nxt = left_r - 2'h1;
      end
   end

   // ==============================
   // sequencing and commit
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         left_r <= 2'h0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         skip_r <= 1'b0;
         dummy_r <= 1'b0;
         skipPend_r <= 1'b0;
         pclChanged_r <= 1'b0;
         progReq_r <= 1'b0;
         progAddr_r <= `FSTA_RST_WORD;
         tableWait_r <= 1'b0;
         tableDest_r <= {`FSTA_DM_AW{1'b0}};
         peekData_r <= `FSTA_RST_BYTE;
         work_register_r <= `FSTA_RST_BYTE;
         table_high_byte_r <= `FSTA_RST_BYTE;
         table_pointer_r <= `FSTA_RST_BYTE;
         zeroFlag_r <= 1'b0;
         carryFlag_r <= 1'b0;
         half_carry_flag_r <= 1'b0;
         signed_wrap_flag_r <= 1'b0;
         signed_carry_flag_r <= 1'b0;
         for (i = 0; i < `FSTA_DM_DEPTH; i = i + 1) begin
            mem_r[i] <= `FSTA_RST_BYTE;
         end
      end else if (!rstSync_r) begin
         state_r <= ST_IDLE;
      end else begin
         peekData_r <= mem_r[peekAddr];
         progReq_r <= 1'b0;
         pclChanged_r <= 1'b0;
         if (accept) begin
            state_r <= ST_RUN;
            busy_r <= 1'b1;
            left_r <= len - 2'h1;
            done_r <= (len == `FSTA_CYC_BASE);
            skip_r <= doSkip && (len == `FSTA_CYC_BASE);
            skipPend_r <= doSkip;
            dummy_r <= 1'b0;
            if (memWr) begin
               mem_r[farAddr] <= memVal;
               pclChanged_r <= (farAddr == `FSTA_PCL_ADDR);
            end
            if (workWr) begin
               work_register_r <= workVal;
            end
            if (arithFlags) begin
               zeroFlag_r <= (sum[7:0] == 8'h00); // [RULE_22]
               carryFlag_r <= sum[8]; // [RULE_22]
               half_carry_flag_r <= sum[9]; // [RULE_22]
               signed_wrap_flag_r <= sum[10]; // [RULE_22]
               signed_carry_flag_r <= sum[10] ^ sum[7];
            end
            if (zeroOnly) begin
               zeroFlag_r <= (workVal == 8'h00); // [RULE_20] [RULE_21]
            end
            if (isTable) begin
               table_pointer_r <= ptrUsed; // [RULE_11]
               progAddr_r <= {pageUsed, ptrUsed}; // [RULE_09]
               progReq_r <= 1'b1;
               tableWait_r <= 1'b1;
               tableDest_r <= farAddr;
            end
         end else if (state_r == ST_RUN) begin
            left_r <= left_nxt;
            if (tableWait_r && !progReq_r) begin
               // program word answers in the cycle after the request
               table_high_byte_r <= progWord[15:8]; // [RULE_09]
               mem_r[tableDest_r] <= progWord[7:0]; // [RULE_09]
               pclChanged_r <= (tableDest_r == `FSTA_PCL_ADDR);
               tableWait_r <= 1'b0;
            end
            if (left_r == 2'h0) begin
               state_r <= ST_IDLE;
               busy_r <= 1'b0;
               done_r <= 1'b0;
               skip_r <= 1'b0;
               dummy_r <= 1'b0;
               skipPend_r <= 1'b0;
            end else begin
               done_r <= (left_r == 2'h1);
               skip_r <= skipPend_r && (left_r == 2'h1);
               // last cycle of a skip runs the discarded instruction
               dummy_r <= skipPend_r && (left_r == 2'h1); // [RULE_23]
            end
         end
      end
   end
endmodule // fsta_exec_unit

// ==== fsta_exec_unit_chk.sv ====
// checker for the far skip / table / add execution unit
// assumes it is bound onto the fsta_exec_unit ports
`timescale 1ns/100ps
module fsta_exec_unit_chk (
   // clock and reset
   input wire clk,
   input wire nrst,
   // status
   input wire busy_r,
   input wire done_r,
   input wire skip_r,
   input wire dummy_r,
   input wire progReq_r,
   // registers and flags
   input wire [7:0] table_high_byte_r,
   input wire [7:0] table_pointer_r,
   input wire zeroFlag_r,
   input wire carryFlag_r,
   input wire half_carry_flag_r,
   input wire signed_wrap_flag_r,
   input wire signed_carry_flag_r
);
   // ==============================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_done_busy: assert property (done_r |-> busy_r) else $error("done without busy");
   a_dummy_skip: assert property (dummy_r |-> skip_r && done_r) else $error("lone dummy");
   a_skip_three: assert property (skip_r |-> $past(busy_r, 2) && !$past(busy_r, 3))
      else $error("skip not in cycle three");
   a_busy_max: assert property ($rose(busy_r) |-> ##[0:2] done_r) else $error("op too long");
   a_done_drop: assert property (done_r |=> !busy_r) else $error("busy after done");
   a_req_pulse: assert property (progReq_r |=> !progReq_r && busy_r) else $error("req");
   a_req_done: assert property (progReq_r |-> ##2 done_r && !skip_r) else $error("fetch");
   a_flags_keep: assert property (busy_r && !done_r |=> $stable({zeroFlag_r, carryFlag_r,
      half_carry_flag_r, signed_wrap_flag_r, signed_carry_flag_r})) else $error("flags moved");
   a_ptr_accept: assert property ($changed(table_pointer_r) |-> $rose(busy_r))
      else $error("pointer moved late");
   a_high_fetch: assert property ($changed(table_high_byte_r) |-> done_r && $past(progReq_r, 2))
      else $error("table high moved");
endmodule // fsta_exec_unit_chk

// ==== test_fsta_exec_unit.sv ====
// testbench for the far skip / table / add execution unit
// assumes fsta_map.vh on the include path; bench drives every input
`timescale 1ns/100ps
`include "fsta_map.vh"
module test_fsta_exec_unit;
   // ==============================
   // stimulus and observation
   reg clk, nrst, start;
   reg [4:0] opcode;
   reg [`FSTA_DM_AW-1:0] farAddr, peekAddr;
   reg [2:0] bitSel;
   reg [7:0] literal, tablePage, v;
   reg [15:0] progWord;
   wire progReq_r, busy_r, done_r, skip_r, dummy_r, pclChanged_r;
   wire [15:0] progAddr_r;
   wire [7:0] peekData_r, work_register_r, table_high_byte_r, table_pointer_r;
   wire zeroFlag_r, carryFlag_r, half_carry_flag_r, signed_wrap_flag_r, signed_carry_flag_r;
   wire [4:0] flags = {signed_wrap_flag_r, half_carry_flag_r, carryFlag_r, zeroFlag_r,
      signed_carry_flag_r};
   integer bad_count, compares, n;
   reg sk, dm, pc;
   reg [4:0] fl;
   fsta_exec_unit u_dut (.clk(clk), .nrst(nrst), .start(start), .opcode(opcode),
      .farAddr(farAddr), .bitSel(bitSel), .literal(literal), .tablePage(tablePage),
      .progWord(progWord), .progReq_r(progReq_r), .progAddr_r(progAddr_r),
      .peekAddr(peekAddr), .peekData_r(peekData_r), .busy_r(busy_r), .done_r(done_r),
      .skip_r(skip_r), .dummy_r(dummy_r), .pclChanged_r(pclChanged_r),
      .work_register_r(work_register_r), .table_high_byte_r(table_high_byte_r),
      .table_pointer_r(table_pointer_r), .zeroFlag_r(zeroFlag_r), .carryFlag_r(carryFlag_r),
      .half_carry_flag_r(half_carry_flag_r), .signed_wrap_flag_r(signed_wrap_flag_r),
      .signed_carry_flag_r(signed_carry_flag_r));
   // ==============================
   // shared tasks
   task final_report;
      begin
         $display("compares %0d mismatches %0d", compares, bad_count);
         if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input string nm, input [23:0] seen, input [23:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
            bad_count = bad_count + 1;
         end
      end
   endtask
   // literal doubles as bit select, page and low program word; keeps arguments few
   task op(input [4:0] c, input [`FSTA_DM_AW-1:0] a, input [7:0] l);
      integer k;
      begin
         @(posedge clk);
         opcode <= c;
         farAddr <= a;
         literal <= l;
         bitSel <= l[2:0];
         tablePage <= l;
         progWord <= {~l, l};
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         n = 0;
         pc = 1'b0;
         for (k = 0; k < 8 && n == 0; k = k + 1) begin
            @(negedge clk);
            if (pclChanged_r === 1'b1)
               pc = 1'b1;
            if (done_r === 1'b1)
               n = k + 1;
         end
         sk = skip_r;
         dm = dummy_r;
         if (n == 0) begin
            bad_count = bad_count + 1;
            final_report;
         end
      end
   endtask
   task opx(input [4:0] c, input [`FSTA_DM_AW-1:0] a, input [7:0] l, input [1:0] en,
      input es);
      begin
         op(c, a, l);
         chk("cycles skip dummy", {n[1:0], sk, dm}, {en, es, es});
      end
   endtask
   task chm(input [`FSTA_DM_AW-1:0] a, input [7:0] e);
      begin
         @(posedge clk);
         peekAddr <= a;
         @(posedge clk);
         @(negedge clk);
         v = peekData_r;
         chk("mem", v, e);
      end
   endtask
   task setw(input [7:0] x);
      begin
         op(`FSTA_OP_AND_IMM, 0, 8'h00);
         op(`FSTA_OP_ADD_IMM, 0, x);
      end
   endtask
   task setm(input [`FSTA_DM_AW-1:0] a, input [7:0] x);
      begin
         op(`FSTA_OP_ZERO_FILL, a, 0);
         setw(x);
         op(`FSTA_OP_ADD_MEM, a, 0);
      end
   endtask
   function [12:0] addf(input [7:0] x, input [7:0] y, input ci);
      reg [8:0] s;
      reg [4:0] h;
      reg ov;
      begin
         s = x + y + ci;
         h = x[3:0] + y[3:0] + ci;
         ov = (x[7] == y[7]) && (s[7] != x[7]);
         addf = {ov, h[4], s[8], s[7:0] == 8'h00, ov ^ s[7], s[7:0]};
      end
   endfunction
   // ==============================
   // scenarios
   task t_table;
      begin
         fl = flags;
         opx(`FSTA_OP_TABLE_PAGE, 6'h30, 8'h12, 3, 0);
         chk("addr", progAddr_r, 16'h1200);
         chk("high", table_high_byte_r, 8'hED);
         chm(6'h30, 8'h12);
         opx(`FSTA_OP_TABLE_FINAL, 6'h31, 8'h5A, 3, 0);
         chk("addr", progAddr_r, 16'hFF00);
         chm(6'h31, 8'h5A);
         opx(`FSTA_OP_PREINC_PAGE, 6'h32, 8'h34, 3, 0);
         chk("addr", progAddr_r, 16'h3401);
         opx(`FSTA_OP_PREINC_FINAL, 6'h33, 8'h77, 3, 0);
         chk("ptr addr", {table_pointer_r, progAddr_r}, 24'h02_FF02);
         chk("high flags", {table_high_byte_r, flags}, {8'h88, fl});
         $display("table test done");
      end
   endtask
   task t_skip;
      begin
         setm(6'h35, 8'h00);
         fl = flags;
         opx(`FSTA_OP_SKIP_ZERO, 6'h35, 0, 3, 1);
         opx(`FSTA_OP_SKIP_NONZERO, 6'h35, 0, 2, 0);
         chk("flags", flags, fl);
         setw(8'h5A);
         opx(`FSTA_OP_SKIP_ZERO_MOVE, 6'h35, 0, 3, 1);
         chk("work", work_register_r, 8'h00);
         setm(6'h21, 8'h80);
         opx(`FSTA_OP_SKIP_ZERO, 6'h21, 0, 2, 0);
         opx(`FSTA_OP_SKIP_NONZERO, 6'h21, 0, 3, 1);
         opx(`FSTA_OP_SKIP_BIT_CLEAR, 6'h21, 7, 2, 0);
         opx(`FSTA_OP_SKIP_BIT_SET, 6'h21, 7, 3, 1);
         opx(`FSTA_OP_SKIP_BIT_CLEAR, 6'h21, 6, 3, 1);
         opx(`FSTA_OP_SKIP_ZERO_MOVE, 6'h21, 0, 2, 0);
         chk("work", work_register_r, 8'h80);
         setm(6'h3F, 8'hFF);
         opx(`FSTA_OP_INCR_SKIP, 6'h3F, 0, 3, 1);
         chm(6'h3F, 8'h00);
         opx(`FSTA_OP_DECR_SKIP, 6'h3F, 0, 2, 0);
         chm(6'h3F, 8'hFF);
         setm(6'h3E, 8'h01);
         opx(`FSTA_OP_DECR_SKIP_WORK, 6'h3E, 0, 3, 1);
         chk("work", work_register_r, 8'h00);
         opx(`FSTA_OP_INCR_SKIP_WORK, 6'h3E, 0, 2, 0);
         chk("work", work_register_r, 8'h02);
         chm(6'h3E, 8'h01);
         $display("skip test done");
      end
   endtask
   task t_fill;
      begin
         opx(`FSTA_OP_ONES_FILL, 6'h1A, 0, 2, 0);
         chk("pcl", pc, 1'b0);
         chm(6'h1A, 8'hFF);
         opx(`FSTA_OP_ZERO_FILL, 6'h1A, 0, 2, 0);
         chm(6'h1A, 8'h00);
         setm(6'h1B, 8'h3C);
         fl = flags;
         opx(`FSTA_OP_NIBBLE_MEM, 6'h1B, 0, 2, 0);
         chm(6'h1B, 8'hC3);
         opx(`FSTA_OP_NIBBLE_WORK, 6'h1B, 0, 2, 0);
         chk("work flags", {work_register_r, flags}, {8'h3C, fl});
         chm(6'h1B, 8'hC3);
         opx(`FSTA_OP_ONES_FILL, `FSTA_PCL_ADDR, 0, 3, 0);
         chk("pcl", pc, 1'b1);
         chm(`FSTA_PCL_ADDR, 8'hFF);
         $display("fill test done");
      end
   endtask
   task t_arith;
      begin
         setm(6'h14, 8'h01);
         setw(8'hFF);
         op(`FSTA_OP_ADD_WORK, 6'h14, 0);
         chk("add", {flags, work_register_r}, addf(8'hFF, 8'h01, 0));
         op(`FSTA_OP_ADC_WORK, 6'h14, 0);
         chk("adc", {flags, work_register_r}, addf(8'h00, 8'h01, 1));
         op(`FSTA_OP_ADC_MEM, 6'h14, 0);
         chm(6'h14, 8'h03);
         chk("add_with_carry_to_memory", {flags, work_register_r}, {addf(8'h02, 8'h01, 0) >> 8, 8'h02});
         op(`FSTA_OP_ADD_MEM, 6'h14, 0);
         chm(6'h14, 8'h05);
         op(`FSTA_OP_ADD_IMM, 0, 8'h7E);
         chk("addi", {flags, work_register_r}, addf(8'h02, 8'h7E, 0));
         fl = flags;
         op(`FSTA_OP_AND_IMM, 0, 8'hC0);
         chk("andi", {flags, work_register_r}, {fl[4:2], 1'b0, fl[0], 8'h80});
         op(`FSTA_OP_AND_WORK, 6'h14, 0);
         chk("and", {flags, work_register_r}, {fl[4:2], 1'b1, fl[0], 8'h00});
         $display("arith test done");
      end
   endtask
   // ==============================
   // clock and main sequence
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      nrst = 1'b0;
      start = 1'b0;
      opcode = 5'h00;
      farAddr = 0;
      peekAddr = 0;
      bitSel = 3'h0;
      literal = 8'h00;
      tablePage = 8'h00;
      progWord = 16'h0000;
      bad_count = 0;
      compares = 0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_table;
      t_skip;
      t_fill;
      t_arith;
      final_report;
   end
endmodule // test_fsta_exec_unit
bind fsta_exec_unit fsta_exec_unit_chk u_chk (.clk(clk), .nrst(nrst), .busy_r(busy_r),
   .done_r(done_r), .skip_r(skip_r), .dummy_r(dummy_r), .progReq_r(progReq_r),
   .table_high_byte_r(table_high_byte_r), .table_pointer_r(table_pointer_r),
   .zeroFlag_r(zeroFlag_r), .carryFlag_r(carryFlag_r), .half_carry_flag_r(half_carry_flag_r),
   .signed_wrap_flag_r(signed_wrap_flag_r), .signed_carry_flag_r(signed_carry_flag_r));
